//--- system_clock_prescaler.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Timer oscillator runs only while the internal RC clock is selected.
// - External clock enable bit makes timer pin input take external clock while the timer oscillator runs.
// - Clock-out fuse drives system clock on clock pin, also during reset.
// - Clock pin carries the divided system clock for any source.
// - One division factor drives core, memory and peripheral clock enables.
// - Division changes only at period ends, so no short period appears.
// - New rate starts at the first old period end after the switch is pending.
// - Divider counts on the undivided clock; its count is not readable.
// - Change enable sets only on writes with all other bits zero.
// - Enable clears four cycles later or on code write; code locked otherwise.
// - Unlock written again in window neither restarts nor clears it.
// - Reset loads code 0000, or 0011 with divide-by-eight fuse; enable zero.
// - Any division code may be written at run time, whatever the fuse.
// - Codes 0000 to 1000 divide by two to the code; others reserved.
// - Every reset loads the factory trim value; software may overwrite it.
// - Trim bit 7 chooses low or high frequency range; ranges overlap.
// - Trim bits 6 to 0 raise frequency monotonically within the range.
module system_clock_prescaler (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic divEightFuse,
  input wire logic clockOutFuse,
  input wire logic [7:0] factoryTrim,
  input wire logic rcClockSelected,
  output logic coreClockEnable,
  output logic programMemoryClockEnable,
  output logic peripheralIoClockEnable,
  output logic clockOutPin,
  output logic clockOutPinOe,
  output logic [7:0] rcOscillatorTrim,
  output logic trimRangeSelect,
  output logic [6:0] trimValueBits,
  output logic timerOscEnable,
  output logic timerOscExtClock
);

  typedef struct packed {
    logic wrPend;
    clk_presc_pkg::reg_t wrReg;
    logic [31:0] rdData;
    logic pce;
    logic [2:0] pceCount;
    logic [3:0] sel;
    logic [7:0] trim;
    logic extClock;
    logic timerReq;
    logic timerRun;
    logic timerExt;
    logic selWrite;
  } ctrl_state_t;

  ctrl_state_t cur;
  ctrl_state_t next_cur;
  logic accept;
  logic [7:0] wrData;
  logic [3:0] resetSel;
  logic tick;
  logic switchPending;
  clk_presc_pkg::reg_t addrReg;

  // Fuse picks the code loaded at reset
  assign resetSel = divEightFuse ? clk_presc_pkg::SEL_RESET_DIV8 :
    clk_presc_pkg::SEL_RESET_DIV1;

  // Only whole-word transfers on a selected, ready bus are taken
  assign accept = hsel && htrans[1] && hready &&
    (hsize == clk_presc_pkg::HSIZE_WORD);
  assign wrData = hwdata[7:0];
  assign addrReg = clk_presc_pkg::decodeReg(haddr);

  // Register file, unlock sequence and timer oscillator gating
  always_comb begin
    next_cur = cur;
    next_cur.selWrite = 1'b0;
    // Change window times out on its own
    if (cur.pce) begin
      if (cur.pceCount == 3'h0) begin
        next_cur.pce = 1'b0;
      end else begin
        next_cur.pceCount = cur.pceCount - 3'h1;
      end
    end
    // Data phase of a write
    if (cur.wrPend) begin
      case (cur.wrReg)
        clk_presc_pkg::REG_PRESCALE: begin
          if (wrData == clk_presc_pkg::UNLOCK_VALUE) begin
            if (!cur.pce) begin
              next_cur.pce = 1'b1;
              next_cur.pceCount = clk_presc_pkg::PCE_WINDOW - 3'h1;
            end
          end else if (cur.pce && !wrData[clk_presc_pkg::PCE_BIT]) begin
            // Code accepted only inside the window; any code allowed
            next_cur.sel = wrData[clk_presc_pkg::SEL_MSB:
              clk_presc_pkg::SEL_LSB];
            next_cur.pce = 1'b0;
            next_cur.selWrite = 1'b1;
          end
        end
        clk_presc_pkg::REG_TRIM: begin
          next_cur.trim = wrData;
        end
        clk_presc_pkg::REG_ASYNC: begin
          next_cur.extClock = wrData[clk_presc_pkg::ASYNC_EXT_BIT];
          next_cur.timerReq = wrData[clk_presc_pkg::ASYNC_REQ_BIT];
        end
        default: begin
          next_cur.sel = next_cur.sel;
        end
      endcase
    end
    // Pin sharing lets the timer oscillator run only from the RC clock
    next_cur.timerRun = next_cur.timerReq && rcClockSelected;
    next_cur.timerExt = next_cur.extClock && next_cur.timerRun;
    // Address phase
    next_cur.wrPend = accept && hwrite;
    next_cur.wrReg = addrReg;
    next_cur.rdData = 32'h0000_0000;
    if (accept && !hwrite) begin
      case (addrReg)
        clk_presc_pkg::REG_PRESCALE: begin
          next_cur.rdData[clk_presc_pkg::PCE_BIT] = next_cur.pce;
          next_cur.rdData[clk_presc_pkg::SEL_MSB:clk_presc_pkg::SEL_LSB] =
            next_cur.sel;
        end
        clk_presc_pkg::REG_TRIM: begin
          next_cur.rdData[7:0] = next_cur.trim;
        end
        clk_presc_pkg::REG_ASYNC: begin
          next_cur.rdData[clk_presc_pkg::ASYNC_EXT_BIT] = next_cur.extClock;
          next_cur.rdData[clk_presc_pkg::ASYNC_REQ_BIT] = next_cur.timerReq;
          next_cur.rdData[clk_presc_pkg::ASYNC_PEND_BIT] = switchPending;
          next_cur.rdData[clk_presc_pkg::ASYNC_BLOCK_BIT] =
            next_cur.timerReq && !next_cur.timerRun;
        end
        default: begin
          next_cur.rdData = 32'h0000_0000;
        end
      endcase
    end
    // Synchronous reset takes fuse and factory values
    if (rst) begin
      next_cur = '0;
      next_cur.sel = resetSel;
      next_cur.trim = factoryTrim;
    end
  end

  always_ff @(posedge clock) begin
    cur <= next_cur;
  end

  // Glitch-free divider on the undivided clock
  prescale_divider divider (
    .clock(clock),
    .rst(rst),
    .resetSel(resetSel),
    .newSel(cur.sel),
    .newSelValid(cur.selWrite),
    .tick(tick),
    .switchPending(switchPending),
    .activeSel()
  );

  // One enable feeds all three clock domains
  assign coreClockEnable = tick;
  assign programMemoryClockEnable = tick;
  assign peripheralIoClockEnable = tick;

  // Clock output overrides the pin whenever the fuse is set
  assign clockOutPin = tick;
  assign clockOutPinOe = clockOutFuse;

  // Bus answers: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = cur.rdData;

  // Trim value drives the RC oscillator directly
  assign rcOscillatorTrim = cur.trim;
  assign trimRangeSelect = cur.trim[clk_presc_pkg::TRIM_RANGE_BIT];
  assign trimValueBits = cur.trim[6:0];
  assign timerOscEnable = cur.timerRun;
  assign timerOscExtClock = cur.timerExt;

  default clocking busClk @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence unlockWrite;
    cur.wrPend && cur.wrReg == clk_presc_pkg::REG_PRESCALE &&
      wrData == clk_presc_pkg::UNLOCK_VALUE;
  endsequence

  sequence codeWrite;
    cur.wrPend && cur.wrReg == clk_presc_pkg::REG_PRESCALE &&
      !wrData[clk_presc_pkg::PCE_BIT];
  endsequence

  sequence anyPrescaleWrite;
    cur.wrPend && cur.wrReg == clk_presc_pkg::REG_PRESCALE;
  endsequence

  chk_unlock_opens: assert property (
    (unlockWrite and !cur.pce) |=> cur.pce && cur.pceCount == 3'h3)
    else $error("unlock write did not open window");

  chk_pce_other: assert property (
    (anyPrescaleWrite and !cur.pce and wrData[clk_presc_pkg::PCE_BIT] and
      wrData[6:0] != 7'h00) |=> !cur.pce)
    else $error("change enable set by non-unlock write");

  chk_pce_window: assert property (
    $rose(cur.pce) ##1 (cur.pce && !cur.wrPend)[*3] |=> !cur.pce)
    else $error("change window not closed after four cycles");

  chk_no_restart: assert property (
    (unlockWrite and cur.pce and cur.pceCount != 3'h0) |=>
      cur.pce && cur.pceCount == $past(cur.pceCount) - 3'h1)
    else $error("repeated unlock restarted window");

  chk_sel_locked: assert property (
    (anyPrescaleWrite and !cur.pce) |=> $stable(cur.sel))
    else $error("division code changed while locked");

  chk_sel_taken: assert property (
    (codeWrite and cur.pce) |=> (cur.sel == $past(wrData[3:0]) && !cur.pce)
      ##1 switchPending)
    else $error("division code not taken");

  chk_reset_sel: assert property (disable iff (1'b0)
    rst |=> cur.sel == ($past(divEightFuse) ? clk_presc_pkg::SEL_RESET_DIV8 :
      clk_presc_pkg::SEL_RESET_DIV1) && !cur.pce)
    else $error("wrong division after reset");

  chk_reset_trim: assert property (disable iff (1'b0)
    rst |=> rcOscillatorTrim == $past(factoryTrim))
    else $error("factory trim not loaded at reset");

  chk_trim_write: assert property (
    (cur.wrPend && cur.wrReg == clk_presc_pkg::REG_TRIM) |=>
      rcOscillatorTrim == $past(wrData))
    else $error("trim write lost");

  chk_timer_gate: assert property (
    timerOscEnable |-> $past(rcClockSelected))
    else $error("timer oscillator on without RC clock");

  chk_ext_clock: assert property (
    timerOscExtClock |-> timerOscEnable && cur.extClock)
    else $error("external timer clock without enable");

  chk_read_zero: assert property (
    (accept && !hwrite && addrReg == clk_presc_pkg::REG_PRESCALE) |=>
      hrdata[6:4] == 3'h0 && hrdata[31:8] == 24'h000000)
    else $error("unused prescale bits read nonzero");

endmodule : system_clock_prescaler

`default_nettype wire

//--- clk_presc_pkg.sv
package clk_presc_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [31:0] PRESCALE_IDX = 32'h0000_0061;
  localparam logic [31:0] TRIM_IDX = 32'h0000_0066;
  localparam logic [31:0] ASYNC_IDX = 32'h0000_0070;
  localparam logic [31:0] PRESCALE_ADDR = PRESCALE_IDX << 2;
  localparam logic [31:0] TRIM_ADDR = TRIM_IDX << 2;
  localparam logic [31:0] ASYNC_ADDR = ASYNC_IDX << 2;

  // Prescale register fields
  localparam int PCE_BIT = 7;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 0;
  localparam logic [7:0] UNLOCK_VALUE = 8'h80;
  localparam logic [3:0] SEL_RESET_DIV1 = 4'h0;
  localparam logic [3:0] SEL_RESET_DIV8 = 4'h3;
  localparam logic [3:0] SEL_MAX_CODE = 4'h8;
  localparam logic [2:0] PCE_WINDOW = 3'h4;

  // Trim register fields
  localparam int TRIM_RANGE_BIT = 7;

  // Asynchronous status register fields
  localparam int ASYNC_EXT_BIT = 6;
  localparam int ASYNC_REQ_BIT = 3;
  localparam int ASYNC_PEND_BIT = 1;
  localparam int ASYNC_BLOCK_BIT = 0;

  // AHB encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    REG_NONE,
    REG_PRESCALE,
    REG_TRIM,
    REG_ASYNC
  } reg_t;

  // Reload value of the divider: division factor minus one
  function automatic logic [7:0] divLoad(input logic [3:0] sel);
    logic [8:0] full;
    full = 9'h001 << sel;
    if (sel > SEL_MAX_CODE) begin
      divLoad = 8'hFF;
    end else begin
      divLoad = 8'(full - 9'h001);
    end
  endfunction : divLoad

  // Byte address to register
  function automatic reg_t decodeReg(input logic [31:0] addr);
    if (addr == PRESCALE_ADDR) begin
      decodeReg = REG_PRESCALE;
    end else if (addr == TRIM_ADDR) begin
      decodeReg = REG_TRIM;
    end else if (addr == ASYNC_ADDR) begin
      decodeReg = REG_ASYNC;
    end else begin
      decodeReg = REG_NONE;
    end
  endfunction : decodeReg

endpackage : clk_presc_pkg

//--- prescale_divider.sv
`timescale 1ns/1ps
`default_nettype none

module prescale_divider (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] resetSel,
  input wire logic [3:0] newSel,
  input wire logic newSelValid,
  output logic tick,
  output logic switchPending,
  output logic [3:0] activeSel
);

  typedef struct packed {
    logic [7:0] count;
    logic [3:0] activeSel;
    logic [3:0] pendSel;
    logic pending;
    logic tick;
    logic [8:0] gap;
    logic [8:0] period;
  } div_state_t;

  div_state_t cur;
  div_state_t next_cur;

  // Down counter on the undivided clock; a new factor only at a period end
  always_comb begin
    next_cur = cur;
    next_cur.tick = (cur.count == 8'h00);
    if (newSelValid) begin
      next_cur.pending = 1'b1;
      next_cur.pendSel = newSel;
    end
    if (cur.count == 8'h00) begin
      if (cur.pending) begin
        next_cur.activeSel = cur.pendSel;
        next_cur.count = clk_presc_pkg::divLoad(cur.pendSel);
        next_cur.pending = newSelValid;
        next_cur.period = {1'b0, clk_presc_pkg::divLoad(cur.pendSel)} + 9'h001;
      end else begin
        next_cur.count = clk_presc_pkg::divLoad(cur.activeSel);
        next_cur.period = {1'b0, clk_presc_pkg::divLoad(cur.activeSel)}
          + 9'h001;
      end
    end else begin
      next_cur.count = cur.count - 8'h01;
    end
    // Cycles since the last tick, for the period check
    if (cur.tick) begin
      next_cur.gap = 9'h001;
    end else if (cur.gap != 9'h1FF) begin
      next_cur.gap = cur.gap + 9'h001;
    end
    // Reset holds the count at zero, so the pulse train runs at full rate
    if (rst) begin
      next_cur = '0;
      next_cur.tick = 1'b1;
      next_cur.activeSel = resetSel;
    end
  end

  always_ff @(posedge clock) begin
    cur <= next_cur;
  end

  assign tick = cur.tick;
  assign switchPending = cur.pending;
  assign activeSel = cur.activeSel;

  default clocking divClk @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_period_whole: assert property (
    (cur.tick && $past(cur.period) != 9'h000) |-> cur.gap == $past(cur.period))
    else $error("divided period cut short");

  chk_switch_bound: assert property (
    $rose(cur.pending) |-> ##[1:258] !cur.pending)
    else $error("new division not adopted in time");

  chk_switch_edges: assert property (
    (cur.count == 8'h00 && cur.pending) |=> cur.tick ##1 (cur.count ==
      clk_presc_pkg::divLoad(cur.activeSel) - 8'h01 || cur.count == 8'h00))
    else $error("switch not followed by new period");

endmodule : prescale_divider

`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [31:0] PA = clk_presc_pkg::PRESCALE_ADDR;
  localparam logic [31:0] TA = clk_presc_pkg::TRIM_ADDR;
  localparam logic [31:0] AA = clk_presc_pkg::ASYNC_ADDR;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, coreEn, memEn, ioEn, clkOut, clkOutOe;
  logic trimRange, timerEn, timerExt;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic divEightFuse = 1'b0;
  logic clockOutFuse = 1'b0;
  logic [7:0] factoryTrim = 8'h00;
  logic rcClockSelected = 1'b0;
  logic [7:0] trimReg;
  logic [6:0] trimVal;
  int nFail = 0;
  int nChecks = 0;
  int curPeriod = 1;

  // Free-running system clock
  always #25 clock = ~clock;

  system_clock_prescaler u_dut (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .divEightFuse(divEightFuse),
    .clockOutFuse(clockOutFuse), .factoryTrim(factoryTrim),
    .rcClockSelected(rcClockSelected), .coreClockEnable(coreEn),
    .programMemoryClockEnable(memEn), .peripheralIoClockEnable(ioEn),
    .clockOutPin(clkOut), .clockOutPinOe(clkOutOe),
    .rcOscillatorTrim(trimReg), .trimRangeSelect(trimRange),
    .trimValueBits(trimVal), .timerOscEnable(timerEn),
    .timerOscExtClock(timerExt)
  );

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    nChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  // Single closing point of the run
  task automatic giveVerdict();
    if (nFail == 0 && nChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : giveVerdict

  // Division factor expected for a code; reserved codes give 256
  function automatic int expPeriod(input logic [3:0] c);
    return (c > 4'h8) ? 256 : (1 << c);
  endfunction : expPeriod

  // One edge of waiting for hready, bounded
  task automatic waitReady();
    int k;
    k = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 64) begin
        check(32'h0, 32'h1, "bus wait timeout");
        giveVerdict();
      end
      @(posedge clock);
    end
  endtask : waitReady

  // One AHB single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hsize <= clk_presc_pkg::HSIZE_WORD;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    q = hrdata;
    check(32'(hresp), 32'h0, "bus response");
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rdCheck(input logic [31:0] a, input logic [31:0] e,
                         input string what);
    bus(1'b0, a, 32'h0, rd);
    check(rd, e, what);
  endtask : rdCheck

  // Count edges up to the next divided-clock pulse
  task automatic nextPulse(output int k);
    k = 0;
    do begin
      @(posedge clock);
      k++;
      check(32'(clkOut), 32'(coreEn), "clock pin train");
      check({memEn, ioEn}, {2{coreEn}}, "domain enables");
      if (k > 600) begin
        check(32'h0, 32'h1, "divider pulse timeout");
        giveVerdict();
      end
    end while (coreEn !== 1'b1);
  endtask : nextPulse

  // Reset with given fuses and factory trim, then check reload
  task automatic doReset(input logic f8, input logic fo, input logic [7:0] t);
    int p;
    rst <= 1'b1;
    divEightFuse <= f8;
    clockOutFuse <= fo;
    factoryTrim <= t;
    repeat (16) @(posedge clock);
    check(32'(clkOutOe), 32'(fo), "clock out drive in reset");
    check(32'(clkOut), 32'h1, "clock out in reset");
    rst <= 1'b0;
    @(posedge clock);
    rdCheck(TA, {24'h0, t}, "factory trim");
    rdCheck(PA, f8 ? 32'h3 : 32'h0, "fuse reset code");
    curPeriod = f8 ? 8 : 1;
    nextPulse(p);
    nextPulse(p);
    check(32'(p), 32'(curPeriod), "reset period");
  endtask : doReset

  // Timed unlock then new code; watch the switch
  task automatic setCode(input logic [3:0] c);
    int p;
    int mn;
    mn = (curPeriod < expPeriod(c)) ? curPeriod : expPeriod(c);
    wr(PA, 32'h80);
    wr(PA, {28'h0, c});
    rdCheck(PA, {28'h0, c}, "code stored");
    nextPulse(p);
    repeat (3) begin
      nextPulse(p);
      check(32'(p >= mn), 32'h1, "short period in switch");
    end
    nextPulse(p);
    check(32'(p), 32'(expPeriod(c)), "division factor");
    curPeriod = expPeriod(c);
  endtask : setCode

  initial begin
    logic [3:0] codes [10];
    logic [3:0] tmp;
    logic [7:0] v;
    int j;
    void'($urandom(32'hAE0F));
    doReset(1'b1, 1'b1, 8'($urandom()));
    // Code writes while locked or with bad unlock are dropped
    wr(PA, 32'h01);
    rdCheck(PA, 32'h03, "locked code write");
    wr(PA, 32'h81);
    wr(PA, 32'h01);
    rdCheck(PA, 32'h03, "bad unlock");
    wr(PA, 32'h80);
    rdCheck(PA, 32'h83, "unlock visible");
    // Window spans four cycles; one more edge lets it close
    @(posedge clock);
    rdCheck(PA, 32'h03, "window closed");
    wr(PA, 32'h01);
    rdCheck(PA, 32'h03, "late code write");
    // Second unlock in the window neither clears nor restarts it
    wr(PA, 32'h80);
    wr(PA, 32'h80);
    rdCheck(PA, 32'h83, "re-unlock keeps enable");
    wr(PA, 32'h02);
    rdCheck(PA, 32'h03, "re-unlock no restart");
    // Every legal code in shuffled order, then one reserved code
    for (int i = 0; i < 9; i++) begin
      codes[i] = 4'(i);
    end
    for (int i = 8; i > 0; i--) begin
      j = $urandom_range(i);
      tmp = codes[i];
      codes[i] = codes[j];
      codes[j] = tmp;
    end
    codes[9] = 4'(9 + $urandom_range(6));
    foreach (codes[i]) begin
      setCode(codes[i]);
    end
    rdCheck(PA + 32'h0, {28'h0, codes[9]}, "reserved stored");
    wr(PA, 32'h80);
    wr(PA, 32'h70);
    rdCheck(PA, 32'h00, "upper bits read zero");
    // Trim register values drive range and tuning outputs
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom());
      wr(TA, {24'h0, v});
      rdCheck(TA, {24'h0, v}, "trim readback");
      check(32'(trimRange), 32'(v[7]), "trim range");
      check(32'(trimVal), 32'(v[6:0]), "trim tuning");
    end
    // Unmapped place reads zero and does not disturb registers
    wr(32'h0000_0100, 32'hFF);
    rdCheck(32'h0000_0100, 32'h0, "unmapped read");
    rdCheck(TA, {24'h0, v}, "unmapped write");
    // Timer oscillator only with internal RC clock selected
    rcClockSelected <= 1'b0;
    wr(AA, 32'h48);
    repeat (2) @(posedge clock);
    check(32'(timerEn), 32'h0, "timer osc without rc");
    rcClockSelected <= 1'b1;
    repeat (3) @(posedge clock);
    check(32'(timerEn), 32'h1, "timer osc with rc");
    check(32'(timerExt), 32'h1, "external clock on");
    wr(AA, 32'h08);
    repeat (2) @(posedge clock);
    check(32'(timerExt), 32'h0, "external clock off");
    // Reset in mid-run with the other fuse settings
    doReset(1'b0, 1'b0, 8'($urandom()));
    setCode(4'h2);
    giveVerdict();
  end
endmodule : tb

`default_nettype wire
